// ---- pdt_pin_src.sv ----
/* pdt_pin_src: signal source on the timer pin.
   assumes: levels change just after rising i_mclk. */
`timescale 1ns/1ps
module pdt_pin_src (
    input wire logic i_mclk, // system clock
    output logic o_pin // level offered to the pin
);
    initial o_pin = 1'b0;
    // n rising edges, high for hi clocks, then low
    task automatic pulse(input int n, input int hi);
        repeat (n) begin
            repeat (2) @(posedge i_mclk);
            o_pin <= 1'b1;
            repeat (hi) @(posedge i_mclk);
            o_pin <= 1'b0;
        end
        repeat (4) @(posedge i_mclk);
    endtask : pulse
endmodule : pdt_pin_src

// ---- pdt_pkg.sv ----
/*
 * pdt_pkg: constants and types for the prescaled 8-bit down timer.
 * assumes: APB with 32-bit data, byte addresses, 100 MHz clock.
 */
package pdt_pkg;
    // register byte addresses
    localparam logic [7:0] PDT_PSC_ADDR = 8'hD2;
    localparam logic [7:0] PDT_CNT_ADDR = 8'hD3;
    localparam logic [7:0] PDT_CTL_ADDR = 8'hD4;
    localparam logic [7:0] PDT_IST_ADDR = 8'hD8;
    localparam logic [7:0] PDT_IMK_ADDR = 8'hDC;
    // control field positions
    localparam int PDT_ZF_BIT = 7;
    localparam int PDT_IE_BIT = 6;
    localparam int PDT_PO_BIT = 5;
    localparam int PDT_DO_BIT = 4;
    localparam int PDT_PI_BIT = 3;
    // reset values
    localparam logic [7:0] PDT_CNT_RST = 8'hFF;
    localparam logic [6:0] PDT_PSC_RST = 7'h7F;
    localparam logic [7:0] PDT_CTL_RST = 8'h00;
    // timing
    localparam int PDT_INT_DIV = 12;
    localparam logic [3:0] PDT_DIV_LAST = 4'(PDT_INT_DIV - 1);

    typedef enum logic [1:0] {
        PDT_MODE_EVENT = 2'b00,
        PDT_MODE_GATED = 2'b01,
        PDT_MODE_OUT0 = 2'b10,
        PDT_MODE_OUT1 = 2'b11
    } pdt_mode_type;

    typedef struct packed {
        logic zero_flag;
        logic zero_irq_enable;
        logic pin_output_select;
        logic data_out;
        logic prescaler_init;
        logic [2:0] div_select;
    } pdt_ctl_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pdt_apb_req_type;
endpackage : pdt_pkg

// ---- pdt_timer.sv ----
/*
 * pdt_timer: 8-bit down counter behind a 7-bit prescaler, APB slave.
 * assumes: one 100 MHz clock, timer pin synchronous to it.
 */
`timescale 1ns/1ps
module pdt_timer (
    input wire logic i_mclk, // system clock
    input wire logic i_rst_n, // async reset, active low
    input wire pdt_pkg::pdt_apb_req_type i_apb, // apb request
    output logic [31:0] o_prdata, // apb read data
    output logic o_pready, // apb ready
    output logic o_pslverr, // apb error
    input wire logic i_timer_pin, // timer pin input level
    output logic o_timer_pin, // timer pin drive level
    output logic o_timer_pin_oe, // timer pin output enable
    output logic o_zero_irq, // timer request, also wake-up
    output logic o_irq // masked sticky event interrupt
);
    import pdt_pkg::*;

    pdt_ctl_type ctl_ff, nxt_ctl;
    logic [7:0] cnt_ff, nxt_cnt;
    logic [6:0] psc_ff, nxt_psc;
    logic [3:0] div_ff, nxt_div;
    logic pin_ff, nxt_pin;
    logic tap_ff, nxt_tap;
    logic pout_ff, nxt_pout;
    logic poe_ff, nxt_poe;
    logic zirq_ff, nxt_zirq;
    logic [1:0] ist_ff, nxt_ist;
    logic [1:0] imk_ff, nxt_imk;
    logic irq_ff, nxt_irq;
    logic [31:0] rd_ff, nxt_rd;
    logic rdy_ff, nxt_rdy;
    logic err_ff, nxt_err;

    pdt_mode_type mode;
    logic div_tick, ps_in, ps_step, tap, tap_rise, dec_zero, cnt_wr;
    logic acc, wr, rd, mapped;

    // selects the tap for a division of 2^sel
    function automatic logic tap_sel(input logic [2:0] sel,
                                     input logic [6:0] psc,
                                     input logic pin);
        if (sel == 3'h0) begin
            tap_sel = pin;
        end else begin
            tap_sel = psc[sel - 3'h1];
        end
    endfunction : tap_sel

    always_comb begin
        mode = pdt_mode_type'({ctl_ff.pin_output_select,
                               ctl_ff.data_out});
        div_tick = (div_ff == PDT_DIV_LAST);
        acc = i_apb.psel && i_apb.penable;
        wr = acc && i_apb.pwrite;
        rd = acc && !i_apb.pwrite;
        mapped = (i_apb.paddr == PDT_PSC_ADDR)
            || (i_apb.paddr == PDT_CNT_ADDR)
            || (i_apb.paddr == PDT_CTL_ADDR)
            || (i_apb.paddr == PDT_IST_ADDR)
            || (i_apb.paddr == PDT_IMK_ADDR);
        // prescaler input pulse, clock/12 or pin edge
        case (mode)
            PDT_MODE_EVENT: ps_in = i_timer_pin && !pin_ff;
            PDT_MODE_GATED: ps_in = div_tick && i_timer_pin;
            PDT_MODE_OUT0, PDT_MODE_OUT1: ps_in = div_tick;
            default: ps_in = 1'b0;
        endcase
        ps_step = ps_in && ctl_ff.prescaler_init;
        nxt_psc = psc_ff;
        if (!ctl_ff.prescaler_init) begin
            nxt_psc = PDT_PSC_RST;
        end else if (wr && i_apb.paddr == PDT_PSC_ADDR) begin
            nxt_psc = i_apb.pwdata[6:0];
        end else if (ps_step) begin
            nxt_psc = psc_ff - 7'h01;
        end
        // tap follows the prescaler output of the selected stage
        tap = tap_sel(ctl_ff.div_select, nxt_psc, ps_step);
        nxt_tap = ctl_ff.prescaler_init ? tap : 1'b0;
        tap_rise = ctl_ff.prescaler_init && (ctl_ff.div_select == 3'h0
            ? ps_step : (tap && !tap_ff));
        cnt_wr = wr && i_apb.paddr == PDT_CNT_ADDR;
        nxt_cnt = cnt_ff;
        dec_zero = 1'b0;
        if (cnt_wr) begin
            nxt_cnt = i_apb.pwdata[7:0];
        end else if (tap_rise) begin
            nxt_cnt = cnt_ff - 8'h01;
            dec_zero = (cnt_ff == 8'h01);
        end
        nxt_ctl = ctl_ff;
        if (wr && i_apb.paddr == PDT_CTL_ADDR) begin
            nxt_ctl = pdt_ctl_type'(i_apb.pwdata[7:0]);
        end
        if (dec_zero || (cnt_wr && i_apb.pwdata[7:0] == 8'h00)) begin
            nxt_ctl.zero_flag = 1'b1;
        end
        nxt_div = div_tick ? 4'h0 : div_ff + 4'h1;
        nxt_pin = i_timer_pin;
        nxt_poe = nxt_ctl.pin_output_select;
        // transparent while flag high, holds otherwise
        nxt_pout = nxt_ctl.zero_flag ? nxt_ctl.data_out : pout_ff;
        nxt_zirq = nxt_ctl.zero_flag && nxt_ctl.zero_irq_enable;
        // sticky events: bit0 zero flag rise, bit1 count wrap
        nxt_ist = ist_ff;
        if (rd && i_apb.paddr == PDT_IST_ADDR) begin
            nxt_ist = 2'b00;
        end
        if (nxt_ctl.zero_flag && !ctl_ff.zero_flag) begin
            nxt_ist[0] = 1'b1;
        end
        if (tap_rise && !cnt_wr && cnt_ff == 8'h00) begin
            nxt_ist[1] = 1'b1;
        end
        nxt_imk = imk_ff;
        if (wr && i_apb.paddr == PDT_IMK_ADDR) begin
            nxt_imk = i_apb.pwdata[1:0];
        end
        nxt_irq = |(nxt_ist & nxt_imk);
        nxt_rdy = i_apb.psel && !i_apb.penable;
        nxt_err = i_apb.psel && !i_apb.penable && !mapped;
        nxt_rd = 32'h0000_0000;
        if (i_apb.psel && !i_apb.penable && !i_apb.pwrite) begin
            case (i_apb.paddr)
                PDT_PSC_ADDR: nxt_rd = {25'h0, psc_ff};
                PDT_CNT_ADDR: nxt_rd = {24'h0, cnt_ff};
                PDT_CTL_ADDR: nxt_rd = {24'h0, ctl_ff};
                PDT_IST_ADDR: nxt_rd = {30'h0, ist_ff};
                PDT_IMK_ADDR: nxt_rd = {30'h0, imk_ff};
                default: nxt_rd = 32'h0000_0000;
            endcase
        end
    end

    // prescaler, divider and edge history
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            psc_ff <= PDT_PSC_RST;
            div_ff <= 4'h0;
            pin_ff <= 1'b0;
            tap_ff <= 1'b0;
        end else begin
            psc_ff <= nxt_psc;
            div_ff <= nxt_div;
            pin_ff <= nxt_pin;
            tap_ff <= nxt_tap;
        end
    end

    // count register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= PDT_CNT_RST;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // control, pin drive and timer request
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl_ff <= pdt_ctl_type'(PDT_CTL_RST);
            pout_ff <= 1'b0;
            poe_ff <= 1'b0;
            zirq_ff <= 1'b0;
        end else begin
            ctl_ff <= nxt_ctl;
            pout_ff <= nxt_pout;
            poe_ff <= nxt_poe;
            zirq_ff <= nxt_zirq;
        end
    end

    // event status, mask and interrupt
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ist_ff <= 2'b00;
            imk_ff <= 2'b00;
            irq_ff <= 1'b0;
        end else begin
            ist_ff <= nxt_ist;
            imk_ff <= nxt_imk;
            irq_ff <= nxt_irq;
        end
    end

    // bus answer
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_ff <= 32'h0000_0000;
            rdy_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            rd_ff <= nxt_rd;
            rdy_ff <= nxt_rdy;
            err_ff <= nxt_err;
        end
    end

    assign o_prdata = rd_ff;
    assign o_pready = rdy_ff;
    assign o_pslverr = err_ff;
    assign o_timer_pin = pout_ff;
    assign o_timer_pin_oe = poe_ff;
    assign o_zero_irq = zirq_ff;
    assign o_irq = irq_ff;

    // decoded strobes for the checks below
    logic psc_wr, ctl_wr, setup;
    assign psc_wr = wr && (i_apb.paddr == PDT_PSC_ADDR);
    assign ctl_wr = wr && (i_apb.paddr == PDT_CTL_ADDR);
    assign setup = i_apb.psel && !i_apb.penable;
    stopped_hold_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !ctl_ff.prescaler_init |=> psc_ff == PDT_PSC_RST)
        else $error("prescaler not held while stopped");
    count_frozen_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !ctl_ff.prescaler_init && !cnt_wr |=> $stable(cnt_ff))
        else $error("count moved while stopped");
    psc_load_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ctl_ff.prescaler_init && psc_wr
        |=> psc_ff == $past(i_apb.pwdata[6:0]))
        else $error("prescaler load lost");
    psc_step_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ctl_ff.prescaler_init && ps_in && !psc_wr
        |=> psc_ff == $past(psc_ff) - 7'h01)
        else $error("prescaler did not step");
    psc_idle_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ctl_ff.prescaler_init && !ps_in && !psc_wr
        |=> $stable(psc_ff))
        else $error("prescaler stepped without input");
    div_wrap_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        div_ff == PDT_DIV_LAST |=> div_ff == 4'h0)
        else $error("clock divider did not wrap");
    div_count_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        div_ff != PDT_DIV_LAST |=> div_ff == $past(div_ff) + 4'h1)
        else $error("clock divider did not count");
    event_edge_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        mode == PDT_MODE_EVENT && ctl_ff.prescaler_init && !psc_wr
        && i_timer_pin && !pin_ff |=> psc_ff == $past(psc_ff) - 7'h01)
        else $error("pin edge not counted");
    event_still_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        mode == PDT_MODE_EVENT && ctl_ff.prescaler_init && !psc_wr
        && !(i_timer_pin && !pin_ff) |=> $stable(psc_ff))
        else $error("event prescaler moved without edge");
    gated_high_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        mode == PDT_MODE_GATED && ctl_ff.prescaler_init && !psc_wr
        && i_timer_pin && div_tick |=> psc_ff == $past(psc_ff) - 7'h01)
        else $error("gated prescaler did not step");
    gated_low_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        mode == PDT_MODE_GATED && ctl_ff.prescaler_init && !psc_wr
        && !i_timer_pin |=> $stable(psc_ff))
        else $error("gated prescaler moved");
    out_rate_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ctl_ff.pin_output_select && ctl_ff.prescaler_init && !psc_wr
        && !div_tick |=> $stable(psc_ff))
        else $error("output mode prescaler off rate");
    tap_one_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ctl_ff.prescaler_init && ctl_ff.div_select == 3'h0 && ps_in
        && !cnt_wr |=> cnt_ff == $past(cnt_ff) - 8'h01)
        else $error("divide by one missed a step");
    tap_none_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !tap_rise && !cnt_wr |=> $stable(cnt_ff))
        else $error("count moved without tap");
    zero_sets_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        tap_rise && !cnt_wr && cnt_ff == 8'h01
        |=> ctl_ff.zero_flag && cnt_ff == 8'h00)
        else $error("flag not set at zero");
    write_wins_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        cnt_wr |=> cnt_ff == $past(i_apb.pwdata[7:0]))
        else $error("count write lost");
    write_noflag_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        cnt_wr && i_apb.pwdata[7:0] != 8'h00 && !ctl_ff.zero_flag
        |=> !ctl_ff.zero_flag)
        else $error("flag set during count write");
    wrap_ff_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        tap_rise && !cnt_wr && cnt_ff == 8'h00 |=> cnt_ff == 8'hFF)
        else $error("count did not wrap");
    zero_write_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        cnt_wr && i_apb.pwdata[7:0] == 8'h00 |=> ctl_ff.zero_flag)
        else $error("zero write left flag clear");
    bit7_write_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ctl_wr && i_apb.pwdata[PDT_ZF_BIT] |=> ctl_ff.zero_flag)
        else $error("flag write left flag clear");
    flag_hold_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ctl_ff.zero_flag && !ctl_wr |=> ctl_ff.zero_flag)
        else $error("flag cleared without software");
    ctl_write_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ctl_wr |=> ctl_ff[6:0] == $past(i_apb.pwdata[6:0]))
        else $error("control write lost");
    irq_level_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_zero_irq == (ctl_ff.zero_flag && ctl_ff.zero_irq_enable))
        else $error("zero request wrong");
    irq_wake_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(ctl_ff.zero_flag) && ctl_ff.zero_irq_enable
        |-> o_zero_irq)
        else $error("wake-up request missing");
    oe_mode_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_timer_pin_oe == ctl_ff.pin_output_select)
        else $error("pin direction wrong");
    latch_copy_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ctl_ff.zero_flag |-> o_timer_pin == ctl_ff.data_out)
        else $error("output latch not transparent");
    latch_hold_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !ctl_ff.zero_flag ##1 !ctl_ff.zero_flag |-> $stable(o_timer_pin))
        else $error("output latch not holding");
    rd_cnt_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        setup && !i_apb.pwrite && i_apb.paddr == PDT_CNT_ADDR
        |=> o_prdata == {24'h0, $past(cnt_ff)})
        else $error("count read not live");
    rd_psc_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        setup && !i_apb.pwrite && i_apb.paddr == PDT_PSC_ADDR
        |=> o_prdata == {25'h0, $past(psc_ff)})
        else $error("prescaler read not live");
    rd_ctl_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        setup && !i_apb.pwrite && i_apb.paddr == PDT_CTL_ADDR
        |=> o_prdata == {24'h0, $past(ctl_ff)})
        else $error("control read wrong");
    ready_pulse_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    err_flag_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        setup && !mapped |=> o_pslverr && o_pready)
        else $error("unmapped access not refused");
    flag_event_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(ctl_ff.zero_flag) |-> ist_ff[0])
        else $error("flag event not recorded");
    wrap_event_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        tap_rise && !cnt_wr && cnt_ff == 8'h00 |=> ist_ff[1])
        else $error("wrap event not recorded");
    irq_mask_a:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_irq == |(ist_ff & imk_ff))
        else $error("masked interrupt wrong");
endmodule : pdt_timer

// ---- testbench.sv ----
/* testbench: register and pin scenarios for pdt_timer.
   assumes: pdt_pkg, pdt_timer and pdt_pin_src compiled first. */
`timescale 1ns/1ps
`define CHK(n, e, a) check(n, 32'(e), 32'(a))
module testbench;
    import pdt_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    pdt_apb_req_type req = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, pin_o, pin_oe, zirq, irq, src, pin;
    int errors = 0;
    int comparisons = 0;
    assign pin = pin_oe ? pin_o : src;
    pdt_timer dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_apb(req),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_timer_pin(pin), .o_timer_pin(pin_o),
        .o_timer_pin_oe(pin_oe), .o_zero_irq(zirq), .o_irq(irq));
    pdt_pin_src src_u (.i_mclk(i_mclk), .o_pin(src));
    initial forever #5 i_mclk = ~i_mclk;
    task automatic check(input string n, input logic [31:0] e, a);
        comparisons++;
        if (a !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, a);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_mclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge i_mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge i_mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        if (k >= 20) errors++;
        req <= '0;
    endtask : apb
    task automatic rdc(input string n, input logic [7:0] a, e);
        apb(1'b0, a, 32'h0);
        `CHK(n, e, rd);
    endtask : rdc
    task automatic t_rst();
        rdc("cnt", PDT_CNT_ADDR, 8'hFF);
        rdc("ctl", PDT_CTL_ADDR, 8'h00);
        apb(1'b1, PDT_PSC_ADDR, 32'h10);
        rdc("psc", PDT_PSC_ADDR, 8'h7F);
        rdc("nomap", 8'h00, 8'h00);
        `CHK("slverr", 1'b1, err);
        $display("test reset done");
    endtask : t_rst
    task automatic t_flag();
        apb(1'b1, PDT_CNT_ADDR, 32'h00);
        rdc("zero write", PDT_CTL_ADDR, 8'h80);
        `CHK("irq off", 1'b0, zirq);
        apb(1'b1, PDT_CTL_ADDR, 32'h00);
        apb(1'b1, PDT_CTL_ADDR, 32'hC0);
        rdc("bit7 set", PDT_CTL_ADDR, 8'hC0);
        `CHK("irq on", 1'b1, zirq);
        apb(1'b1, PDT_CTL_ADDR, 32'h08);
        apb(1'b1, PDT_PSC_ADDR, 32'h10);
        rdc("psc load", PDT_PSC_ADDR, 8'h10);
        apb(1'b1, PDT_CTL_ADDR, 32'h00);
        `CHK("irq clr", 1'b0, zirq);
        $display("test flag done");
    endtask : t_flag
    task automatic t_evt();
        apb(1'b0, PDT_IST_ADDR, 32'h0);
        apb(1'b1, PDT_IMK_ADDR, 32'h01);
        apb(1'b1, PDT_CNT_ADDR, 32'h03);
        apb(1'b1, PDT_CTL_ADDR, 32'h08);
        src_u.pulse(3, 2);
        rdc("evt zero", PDT_CTL_ADDR, 8'h88);
        rdc("psc live", PDT_PSC_ADDR, 8'h7C);
        `CHK("irq", 1'b1, irq);
        rdc("status", PDT_IST_ADDR, 8'h01);
        @(posedge i_mclk);
        `CHK("irq read", 1'b0, irq);
        src_u.pulse(1, 2);
        rdc("wrap", PDT_CNT_ADDR, 8'hFF);
        `CHK("irq masked", 1'b0, irq);
        rdc("wrap event", PDT_IST_ADDR, 8'h02);
        apb(1'b1, PDT_CTL_ADDR, 32'h09);
        apb(1'b1, PDT_PSC_ADDR, 32'h08);
        apb(1'b1, PDT_CNT_ADDR, 32'h05);
        src_u.pulse(4, 2);
        rdc("div2", PDT_CNT_ADDR, 8'h03);
        $display("test event done");
    endtask : t_evt
    task automatic t_gate();
        apb(1'b1, PDT_CTL_ADDR, 32'h18);
        apb(1'b1, PDT_CNT_ADDR, 32'h80);
        repeat (60) @(posedge i_mclk);
        rdc("gate low", PDT_CNT_ADDR, 8'h80);
        src_u.pulse(1, 60);
        apb(1'b0, PDT_CNT_ADDR, 32'h0);
        `CHK("gate high", 1'b1, rd[7:0] inside {[8'h7A:8'h7C]});
        $display("test gated done");
    endtask : t_gate
    task automatic t_out();
        apb(1'b1, PDT_CNT_ADDR, 32'hFF);
        apb(1'b1, PDT_CTL_ADDR, 32'hB8);
        repeat (2) @(posedge i_mclk);
        `CHK("oe", 1'b1, pin_oe);
        `CHK("pin copy", 1'b1, pin_o);
        apb(1'b1, PDT_CTL_ADDR, 32'h28);
        repeat (2) @(posedge i_mclk);
        `CHK("pin held", 1'b1, pin_o);
        apb(1'b1, PDT_CTL_ADDR, 32'hA8);
        repeat (2) @(posedge i_mclk);
        `CHK("pin zero", 1'b0, pin_o);
        $display("test output done");
    endtask : t_out
    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        repeat (16) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        t_rst();
        t_flag();
        t_evt();
        t_gate();
        t_out();
        complete_run();
    end
    // tests need a few hundred clocks
    initial begin
        #200000;
        errors++;
        complete_run();
    end
endmodule : testbench
